// ==== rtl/rxfs_regs.sv ====
// Receive FIFO status register bank: min frame length and FIFO counts.
// Assumes register port strobes are synchronous, one cycle each.
`timescale 1ns/1ps
`default_nettype none
`include "rxfs_defs.svh"

module rxfs_regs
    import rxfs_pkg::*;
#(
    parameter int RFC_W = `RXFS_RFC_W,
    parameter int HW_W = `RXFS_HW_W
) (
    input wire logic i_clock,
    input wire logic i_arst_n,
    input wire logic i_clk_en,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [`RXFS_ADDR_W-1:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_lo_frame_commit,
    input wire logic i_hi_frame_commit,
    input wire logic i_lo_frame_done,
    input wire logic i_hi_frame_done,
    input wire logic [1:0] i_lo_hw_in,
    input wire logic [1:0] i_hi_hw_in,
    input wire logic [1:0] i_lo_hw_out,
    input wire logic [1:0] i_hi_hw_out,
    output logic [31:0] o_reg_rdata,
    output logic o_reg_rvalid,
    output logic [`RXFS_MIN_LEN_W-1:0] o_min_frame_bytes
);
    logic rst_meta_r;
    logic rst_sync_r;
    logic [`RXFS_MIN_LEN_W-1:0] min_len_r;
    logic [RFC_W-1:0] lo_rfc_r;
    logic [RFC_W-1:0] hi_rfc_r;
    logic [HW_W-1:0] lo_hw_r;
    logic [HW_W-1:0] hi_hw_r;
    rxfs_word_t rdata_nxt;

    always_ff @(posedge i_clock or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_r <= 1'h0;
            rst_sync_r <= 1'h0;
        end else begin
            rst_meta_r <= 1'h1;
            rst_sync_r <= rst_meta_r;
        end
    end

    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            min_len_r <= `RXFS_MIN_LEN_RST;
        end else if (i_clk_en && i_reg_wr
                     && i_reg_addr == `RXFS_OFS_MIN_LEN) begin
            min_len_r <= i_reg_wdata[`RXFS_MIN_LEN_W-1:0];
        end
    end

    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            o_min_frame_bytes <= `RXFS_MIN_LEN_RST;
        end else if (i_clk_en) begin
            o_min_frame_bytes <= min_len_r;
        end
    end

    // Commit and done in one cycle cancel out
    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            lo_rfc_r <= '0;
            hi_rfc_r <= '0;
        end else if (i_clk_en) begin
            if (i_lo_frame_commit && !i_lo_frame_done) begin
                lo_rfc_r <= lo_rfc_r + 1'h1;
            end else if (!i_lo_frame_commit && i_lo_frame_done) begin
                lo_rfc_r <= lo_rfc_r - 1'h1;
            end
            if (i_hi_frame_commit && !i_hi_frame_done) begin
                hi_rfc_r <= hi_rfc_r + 1'h1;
            end else if (!i_hi_frame_commit && i_hi_frame_done) begin
                hi_rfc_r <= hi_rfc_r - 1'h1;
            end
        end
    end

    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            lo_hw_r <= '0;
            hi_hw_r <= '0;
        end else if (i_clk_en) begin
            lo_hw_r <= lo_hw_r + HW_W'(i_lo_hw_in)
                       - HW_W'(i_lo_hw_out);
            hi_hw_r <= hi_hw_r + HW_W'(i_hi_hw_in)
                       - HW_W'(i_hi_hw_out);
        end
    end

    // Unmapped offsets read zero; reserved bits zero
    always_comb begin
        rdata_nxt = '0;
        unique case (i_reg_addr)
            `RXFS_OFS_MIN_LEN: rdata_nxt[`RXFS_MIN_LEN_W-1:0] = min_len_r;
            `RXFS_OFS_LO_RFC: rdata_nxt[RFC_W-1:0] = lo_rfc_r;
            `RXFS_OFS_HI_RFC: rdata_nxt[RFC_W-1:0] = hi_rfc_r;
            `RXFS_OFS_LO_HW: rdata_nxt[HW_W-1:0] = lo_hw_r;
            `RXFS_OFS_HI_HW: rdata_nxt[HW_W-1:0] = hi_hw_r;
            default: rdata_nxt = '0;
        endcase
    end

    always_ff @(posedge i_clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            o_reg_rdata <= '0;
            o_reg_rvalid <= 1'h0;
        end else if (i_clk_en) begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_nxt;
            end
        end
    end

    // Length field, its copy and its read-back
    min_len_wr_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_reg_wr && i_reg_addr == `RXFS_OFS_MIN_LEN
        |=> min_len_r == $past(i_reg_wdata[`RXFS_MIN_LEN_W-1:0]))
        else $error("min length write lost");

    len_freeze_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        !i_clk_en |=> $stable(min_len_r) && $stable(o_min_frame_bytes))
        else $error("min length moved while frozen");

    min_out_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en ##1 i_clk_en |-> o_min_frame_bytes == $past(min_len_r))
        else $error("min length output stale");

    len_read_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_reg_rd && i_reg_addr == `RXFS_OFS_MIN_LEN
        |=> o_reg_rvalid && o_reg_rdata == {16'h0000, $past(min_len_r)})
        else $error("min length read wrong");

    // Frame counts
    lo_rfc_up_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_lo_frame_commit && !i_lo_frame_done
        |=> lo_rfc_r == $past(lo_rfc_r) + 1'h1)
        else $error("low frame count not raised");

    lo_rfc_dn_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_lo_frame_done && !i_lo_frame_commit
        |=> lo_rfc_r == $past(lo_rfc_r) - 1'h1)
        else $error("low frame count not lowered");

    rfc_read_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_reg_rd && i_reg_addr == `RXFS_OFS_LO_RFC
        |=> o_reg_rvalid && o_reg_rdata[31:RFC_W] == '0
        && o_reg_rdata[RFC_W-1:0] == $past(lo_rfc_r))
        else $error("low frame count read wrong");

    hi_rfc_up_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_hi_frame_commit && !i_hi_frame_done
        |=> hi_rfc_r == $past(hi_rfc_r) + 1'h1)
        else $error("high frame count not raised");

    hi_rfc_dn_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_hi_frame_done && !i_hi_frame_commit
        |=> hi_rfc_r == $past(hi_rfc_r) - 1'h1)
        else $error("high frame count not lowered");

    hi_rfc_read_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_reg_rd && i_reg_addr == `RXFS_OFS_HI_RFC
        |=> o_reg_rvalid && o_reg_rdata[31:RFC_W] == '0
        && o_reg_rdata[RFC_W-1:0] == $past(hi_rfc_r))
        else $error("high frame count read wrong");

    rfc_cancel_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_hi_frame_commit && i_hi_frame_done
        |=> $stable(hi_rfc_r))
        else $error("commit and done did not cancel");

    rfc_freeze_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        !i_clk_en |=> $stable(lo_rfc_r) && $stable(hi_rfc_r))
        else $error("frame count moved while frozen");

    // Half-word counts
    lo_hw_track_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en |=> lo_hw_r == HW_W'($past(lo_hw_r)
        + $past(i_lo_hw_in) - $past(i_lo_hw_out)))
        else $error("low half-word count wrong");

    lo_hw_read_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_reg_rd && i_reg_addr == `RXFS_OFS_LO_HW
        |=> o_reg_rvalid && o_reg_rdata[31:HW_W] == '0
        && o_reg_rdata[HW_W-1:0] == $past(lo_hw_r))
        else $error("low half-word count read wrong");

    hi_hw_track_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en |=> hi_hw_r == HW_W'($past(hi_hw_r)
        + $past(i_hi_hw_in) - $past(i_hi_hw_out)))
        else $error("high half-word count wrong");

    hi_hw_hold_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        !i_clk_en |=> hi_hw_r == $past(hi_hw_r))
        else $error("high half-word count moved while frozen");

    hi_hw_read_a: assert property (
        @(posedge i_clock) disable iff (!rst_sync_r)
        i_clk_en && i_reg_rd && i_reg_addr == `RXFS_OFS_HI_HW
        |=> o_reg_rvalid && o_reg_rdata[31:HW_W] == '0
        && o_reg_rdata[HW_W-1:0] == $past(hi_hw_r))
        else $error("high half-word count read wrong");
endmodule
`default_nettype wire

// ==== inc/rxfs_defs.svh ====
// Offsets, field widths, reset values for the receive FIFO status bank.
// Assumes word-indexed register addresses on the device register port.
`ifndef RXFS_DEFS_SVH
`define RXFS_DEFS_SVH

`define RXFS_ADDR_W 8
`define RXFS_OFS_MIN_LEN 8'hB7
`define RXFS_OFS_LO_RFC 8'hB8
`define RXFS_OFS_HI_RFC 8'hB9
`define RXFS_OFS_LO_HW 8'hBA
`define RXFS_OFS_HI_HW 8'hBB
`define RXFS_MIN_LEN_W 16
`define RXFS_RFC_W 9
`define RXFS_HW_W 14
`define RXFS_MIN_LEN_RST 16'h0040

`endif

// ==== inc/rxfs_pkg.sv ====
// Types for the receive FIFO status bank.
// Assumes rxfs_defs.svh is on the include path.
`include "rxfs_defs.svh"
package rxfs_pkg;
    typedef logic [31:0] rxfs_word_t;
    typedef logic [`RXFS_ADDR_W-1:0] rxfs_addr_t;
endpackage

// ==== verif/tb.sv ====
// Bench for the receive FIFO status bank.
// Assumes word-indexed addresses and a 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, ce = 1;
    logic lc = 0, hc = 0, ld = 0, hd = 0;
    logic [1:0] li = 0, hi = 0, lo = 0, ho = 0;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0;
    wire logic [31:0] rdata;
    wire logic rv;
    wire logic [15:0] mfb;
    int err_count = 0, checks = 0, cyc = 0;
    rxfs_regs rxfs_regs_i (.i_clock(clk), .i_arst_n(rst_n), .i_clk_en(ce),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wd),
        .i_lo_frame_commit(lc), .i_hi_frame_commit(hc),
        .i_lo_frame_done(ld), .i_hi_frame_done(hd), .i_lo_hw_in(li),
        .i_hi_hw_in(hi), .i_lo_hw_out(lo), .i_hi_hw_out(ho),
        .o_reg_rdata(rdata), .o_reg_rvalid(rv), .o_min_frame_bytes(mfb));
    initial forever #5 clk = ~clk;
    task give_verdict;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            $display("MISMATCH %0t timeout", $time);
            give_verdict();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [31:0] d);
        @(negedge clk) {wr, addr, wd} = {1'b1, a, d};
        @(negedge clk) wr = 0;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp);
        int i;
        @(negedge clk) {rd, addr} = {1'b1, a};
        @(negedge clk) rd = 0;
        for (i = 0; i < 3 && rv !== 1'b1; i++)
            @(negedge clk);
        chk({31'h0, rv}, 32'h1);
        chk(rdata, exp);
        @(negedge clk) chk({31'h0, rv}, 32'h0);
    endtask
    task t_reset;
        chk({16'h0, mfb}, 32'h40);
        rchk(8'hB7, 32'h40);
        rchk(8'hB8, 32'h0);
        rchk(8'hB9, 32'h0);
        rchk(8'hBA, 32'h0);
        rchk(8'hBB, 32'h0);
    endtask
    task t_minlen;
        wreg(8'hB7, 32'hFFFF_1234);
        rchk(8'hB7, 32'h1234);
        chk({16'h0, mfb}, 32'h1234);
        wreg(8'hB8, 32'h55);
        rchk(8'hB8, 32'h0);
        rchk(8'h10, 32'h0);
    endtask
    task t_frames;
        // Low: +1 +1 (+1-1) -1; high: +1 -1 -1 wraps, (+1-1)
        @(negedge clk) {lc, hc} = 2'b11;
        @(negedge clk) hc = 0;
        @(negedge clk) ld = 1;
        @(negedge clk) {lc, hd} = 2'b01;
        @(negedge clk) {ld, hd} = 2'b01;
        @(negedge clk) {hc, hd} = 2'b11;
        @(negedge clk) {hc, hd} = 2'b00;
        // Counts are read back here and checked against the expected values
        rchk(8'hB8, 32'h1);
        rchk(8'hB9, 32'h1FF);
    endtask
    task t_halfwords;
        @(negedge clk) {li, hi} = {2'h3, 2'h2};
        @(negedge clk) {li, hi, lo} = {2'h1, 2'h0, 2'h2};
        @(negedge clk) {li, lo, ho} = {2'h0, 2'h0, 2'h3};
        @(negedge clk) ho = 0;
        rchk(8'hBA, 32'h2);
        rchk(8'hBB, 32'h3FFF);
    endtask
    task t_freeze;
        // Enable low: strobes and counter events must be ignored
        @(negedge clk) ce = 0;
        @(negedge clk) {lc, hc, li, hi} = {2'b11, 2'h1, 2'h2};
        {wr, rd, addr, wd} = {2'b11, 8'hB7, 32'h0000_0099};
        repeat (2) @(negedge clk);
        chk({31'h0, rv}, 32'h0);
        {lc, hc, li, hi, wr, rd} = '0;
        ce = 1;
        chk({16'h0, mfb}, 32'h1234);
        rchk(8'hB7, 32'h1234);
        rchk(8'hB8, 32'h1);
        rchk(8'hB9, 32'h1FF);
        rchk(8'hBA, 32'h2);
        rchk(8'hBB, 32'h3FFF);
    endtask
    task t_midreset;
        wreg(8'hB7, 32'h0000_00C8);
        @(negedge clk) {lc, li} = {1'b1, 2'h1};
        @(negedge clk) {lc, li} = {1'b0, 2'h0};
        @(negedge clk) rst_n = 0;
        repeat (4) @(negedge clk);
        chk({16'h0, mfb}, 32'h40);
        chk({31'h0, rv}, 32'h0);
        rst_n = 1;
        repeat (3) @(negedge clk);
        chk({16'h0, mfb}, 32'h40);
        rchk(8'hB7, 32'h40);
        rchk(8'hB8, 32'h0);
        rchk(8'hB9, 32'h0);
        rchk(8'hBA, 32'h0);
        rchk(8'hBB, 32'h0);
    endtask
    initial begin
        repeat (4) @(negedge clk);
        rst_n = 1;
        repeat (3) @(negedge clk);
        t_reset();
        t_minlen();
        t_frames();
        t_halfwords();
        t_freeze();
        t_midreset();
        give_verdict();
    end
endmodule
`default_nettype wire
